// ==== rtl/nor_flash_pkg.sv ====
// Shared constants and types of the NOR flash command decoder
package nor_flash_pkg;
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int BLK_BITS = 4;
  localparam int RCR_W = 16;
  localparam int BUF_MAX = 512;
  localparam int BUF_CNT_W = 10;
  localparam int FIFO_DEPTH = 8;
  localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_READ_ID = 8'h90;
  localparam logic [7:0] CMD_READ_QUERY = 8'h98;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_WORD_PROG = 8'h40;
  localparam logic [7:0] CMD_BUF_PROG = 8'he8;
  localparam logic [7:0] CMD_CONFIRM = 8'hd0;
  localparam logic [7:0] CMD_FACTORY_SETUP = 8'h80;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
  localparam logic [7:0] CMD_SUSPEND = 8'hb0;
  localparam logic [7:0] CMD_PROTECT_SETUP = 8'h60;
  localparam logic [7:0] CMD_LOCK = 8'h01;
  localparam logic [7:0] CMD_LOCK_DOWN = 8'h2f;
  localparam logic [7:0] CMD_SET_RCR = 8'h03;
  localparam logic [7:0] CMD_OTP_SETUP = 8'hc0;
  localparam int READY_BIT = 7;
  localparam int ERASE_SUSP_BIT = 6;
  localparam int ERASE_ERR_BIT = 5;
  localparam int PROG_ERR_BIT = 4;
  localparam int PROG_SUSP_BIT = 2;
  localparam logic [7:0] STATUS_RESET = 8'h80;
  typedef enum logic [3:0] {
    MODE_ARRAY = 4'h1, MODE_STATUS = 4'h2, MODE_QUERY = 4'h4, MODE_ID = 4'h8
  } read_mode_t;
  typedef enum logic [2:0] {
    OP_NONE = 3'h0, OP_WORD = 3'h1, OP_BUFFER = 3'h2,
    OP_FACTORY = 3'h3, OP_ERASE = 3'h4, OP_OTP = 3'h5
  } op_kind_t;
  typedef enum logic [11:0] {
    ST_IDLE = 12'h001, ST_PROG_SETUP = 12'h002, ST_BUF_COUNT = 12'h004,
    ST_BUF_LOAD = 12'h008, ST_BUF_CONFIRM = 12'h010, ST_FACT_SETUP = 12'h020,
    ST_ERASE_SETUP = 12'h040, ST_CFG_SETUP = 12'h080, ST_OTP_SETUP = 12'h100,
    ST_BUSY = 12'h200, ST_SUSPENDED = 12'h400, ST_FACT_BUSY = 12'h800
  } dec_state_t;
  typedef struct packed {
    op_kind_t kind;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } op_t;
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } buf_word_t;
  typedef struct packed {
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic address_valid_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq;
  } pin_in_t;
  localparam pin_in_t PIN_IDLE = pin_in_t'({4'hf, {(ADDR_W+DATA_W){1'b0}}});
endpackage

// ==== rtl/nor_flash_command_decoder.sv ====
// Command decoder of a parallel NOR flash, with its load-buffer FIFO
// Contract
// (R1) Code 98 selects query read; reads give query byte on low lines.
// (R2) Code 50 clears all status error bits.
// (R3) Code 40 then one write: that address and data are programmed.
// (R4) During program only status read and suspend are taken.
// (R5) Status shown refreshes only on chip select, output enable or address-valid assert.
// (R6) Host writes read-array after programming to see array data again.
// (R7) Code E8 starts buffered load of up to 512 words.
// (R8) Confirm D0 after loading starts the buffer program.
// (R9) Code 80 then D0 starts factory program; then all commands ignored.
// (R10) Code 20 then D0 erases the addressed block.
// (R11) Erase setup not followed by D0 sets both error bits, status mode.
// (R12) During erase only status read and suspend are taken.
// (R13) Code B0 suspends; suspended flag plus ready shown.
// (R14) Suspension holds until reset or resume.
// (R15) D0 while suspended resumes the operation.
// (R16) Code 60 then anything but 01, D0, 2F, 03 sets both error bits.
// (R17) 60 then 01 locks, 60 then 2F locks down the block.
// (R18) 60 then D0 unlocks, unless the block is locked down.
// (R19) Code C0 then one write programs the OTP or lock register.
// (R20) Setup 60 accepts 03 for read configuration, else sequence error.
// (R21) 60 then 03 stores the address low word; array reads follow.
// (R22) After reset: array read mode, status 80.
// (R23) Program or erase commands select status read; 70 selects it too.
// (R24) Address and data are taken when the write strobe or select rises.
// (R25) Errors stay until 50; decoder returns to idle after an error; FIFO overflow sets program error and loading continues.
// (R26) Ready reads zero while an algorithm runs, one otherwise.
`timescale 1ns/1ns
`default_nettype none
module word_fifo #(
  parameter int WIDTH = 40,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
  logic push, pop;
  assign in_ready = (wr_ptr_reg - rd_ptr_reg) != (PW+1)'(DEPTH);
  assign out_valid = wr_ptr_reg != rd_ptr_reg;
  assign out_data = mem_reg[rd_ptr_reg[PW-1:0]];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  always_comb begin
    wr_ptr_next = push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
    rd_ptr_next = pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
    end
  end
  // Storage carries no reset; only pointers decide what is valid
  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg[PW-1:0]] <= in_data;
    end
  end
endmodule

module nor_flash_command_decoder
  import nor_flash_pkg::*;
#(
  parameter int BLK_W = BLK_BITS,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic address_valid_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] dq_in,
  output logic [DATA_W-1:0] dq_out,
  output logic dq_oe,
  input wire logic [DATA_W-1:0] array_rdata,
  input wire logic [7:0] query_rdata,
  input wire logic [DATA_W-1:0] id_rdata,
  output logic op_valid,
  output var op_t op,
  output logic algo_suspend,
  input wire logic algo_done,
  output logic buf_valid,
  output var buf_word_t buf_word,
  input wire logic buf_ready,
  output logic [7:0] status,
  output logic [RCR_W-1:0] read_config,
  output logic [2**BLK_W-1:0] block_locked,
  output logic [2**BLK_W-1:0] block_lockdown
);
  localparam int NBLK = 2**BLK_W;
  pin_in_t pin_now, s1_reg, s2_reg, s3_reg, filt_reg, filt_next;
  logic wr_evt_reg, wr_evt_next, refresh;
  logic [ADDR_W-1:0] wr_addr_reg, wr_addr_next;
  logic [DATA_W-1:0] wr_data_reg, wr_data_next;
  logic [7:0] code;
  logic [BLK_W-1:0] blk;
  assign pin_now = {ce_n, we_n, oe_n, address_valid_n, addr, dq_in};

  // A bit is accepted only once the second and third stages agree
  always_comb begin
    filt_next = pin_in_t'((s3_reg & ~(s2_reg ^ s3_reg)) | (filt_reg & (s2_reg ^ s3_reg)));
    wr_evt_next = (filt_next.ce_n | filt_next.we_n) & ~(filt_reg.ce_n | filt_reg.we_n); // R24
    wr_addr_next = wr_evt_next ? filt_next.addr : wr_addr_reg; // R24
    wr_data_next = wr_evt_next ? filt_next.dq : wr_data_reg; // R24
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_reg <= PIN_IDLE;
      s2_reg <= PIN_IDLE;
      s3_reg <= PIN_IDLE;
      filt_reg <= PIN_IDLE;
      wr_evt_reg <= 1'b0;
      wr_addr_reg <= '0;
      wr_data_reg <= '0;
    end else begin
      s1_reg <= pin_now;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      filt_reg <= filt_next;
      wr_evt_reg <= wr_evt_next;
      wr_addr_reg <= wr_addr_next;
      wr_data_reg <= wr_data_next;
    end
  end
  assign code = wr_data_reg[7:0];
  assign blk = wr_addr_reg[ADDR_W-1 -: BLK_W];
  assign refresh = (~filt_next.ce_n & filt_reg.ce_n) | (~filt_next.oe_n & filt_reg.oe_n)
    | (~filt_next.address_valid_n & filt_reg.address_valid_n); // R5

  dec_state_t state_reg, state_next;
  read_mode_t mode_reg, mode_next;
  op_kind_t kind_reg, kind_next;
  op_t op_reg, op_next;
  logic op_valid_reg, op_valid_next;
  logic prog_err_reg, prog_err_next, erase_err_reg, erase_err_next;
  logic prog_susp_reg, prog_susp_next, erase_susp_reg, erase_susp_next;
  logic [BUF_CNT_W-1:0] left_reg, left_next;
  logic [NBLK-1:0] lock_reg, lock_next, down_reg, down_next;
  logic [RCR_W-1:0] rcr_reg, rcr_next;
  logic fifo_push, fifo_in_ready, ready;
  assign ready = (state_reg != ST_BUSY) && (state_reg != ST_FACT_BUSY); // R26

  always_comb begin
    state_next = state_reg;
    mode_next = mode_reg;
    kind_next = kind_reg;
    op_next = op_reg;
    op_valid_next = 1'b0;
    prog_err_next = prog_err_reg;
    erase_err_next = erase_err_reg;
    prog_susp_next = prog_susp_reg;
    erase_susp_next = erase_susp_reg;
    left_next = left_reg;
    lock_next = lock_reg;
    down_next = down_reg;
    rcr_next = rcr_reg;
    fifo_push = 1'b0;
    if (wr_evt_reg) begin
      case (state_reg)
        ST_IDLE, ST_SUSPENDED: begin
          if (code == CMD_READ_ARRAY) begin
            mode_next = MODE_ARRAY;
          end else if (code == CMD_READ_STATUS) begin
            mode_next = MODE_STATUS; // R23
          end else if (code == CMD_READ_ID) begin
            mode_next = MODE_ID;
          end else if (code == CMD_READ_QUERY) begin
            mode_next = MODE_QUERY; // R1
          end else if (code == CMD_CLEAR_STATUS) begin
            prog_err_next = 1'b0; // R2 R25
            erase_err_next = 1'b0; // R2 R25
          end else if (state_reg == ST_SUSPENDED) begin // R14
            if (code == CMD_CONFIRM) begin
              state_next = ST_BUSY; // R15
              prog_susp_next = 1'b0;
              erase_susp_next = 1'b0;
            end
          end else if (code == CMD_WORD_PROG) begin
            state_next = ST_PROG_SETUP; // R3
            mode_next = MODE_STATUS; // R23
          end else if (code == CMD_BUF_PROG) begin
            state_next = ST_BUF_COUNT; // R7
            mode_next = MODE_STATUS; // R23
          end else if (code == CMD_FACTORY_SETUP) begin
            state_next = ST_FACT_SETUP; // R9
            mode_next = MODE_STATUS;
          end else if (code == CMD_ERASE_SETUP) begin
            state_next = ST_ERASE_SETUP; // R10
            mode_next = MODE_STATUS; // R23
          end else if (code == CMD_PROTECT_SETUP) begin
            state_next = ST_CFG_SETUP;
          end else if (code == CMD_OTP_SETUP) begin
            state_next = ST_OTP_SETUP; // R19
            mode_next = MODE_STATUS;
          end
        end
        ST_PROG_SETUP, ST_OTP_SETUP: begin
          kind_next = (state_reg == ST_OTP_SETUP) ? OP_OTP : OP_WORD; // R3 R19
          op_next = '{kind_next, wr_addr_reg, wr_data_reg}; // R3 R19
          op_valid_next = 1'b1;
          state_next = ST_BUSY;
        end
        ST_BUF_COUNT: begin
          if (wr_data_reg > DATA_W'(BUF_MAX - 1)) begin
            prog_err_next = 1'b1; // R7
            erase_err_next = 1'b1;
            state_next = ST_IDLE;
          end else begin
            left_next = BUF_CNT_W'(wr_data_reg[BUF_CNT_W-2:0]) + BUF_CNT_W'(1); // R7
            op_next.addr = wr_addr_reg;
            state_next = ST_BUF_LOAD;
          end
        end
        ST_BUF_LOAD: begin
          // Host writes cannot be stalled, so a full FIFO drops the word and flags it
          fifo_push = 1'b1; // R7
          prog_err_next = prog_err_reg | ~fifo_in_ready;
          left_next = left_reg - BUF_CNT_W'(1);
          if (left_reg == BUF_CNT_W'(1)) begin
            state_next = ST_BUF_CONFIRM;
          end
        end
        ST_BUF_CONFIRM, ST_FACT_SETUP, ST_ERASE_SETUP: begin
          if (code == CMD_CONFIRM) begin
            kind_next = (state_reg == ST_ERASE_SETUP) ? OP_ERASE : // R10
              (state_reg == ST_FACT_SETUP) ? OP_FACTORY : OP_BUFFER; // R8 R9
            op_next = '{kind_next, wr_addr_reg, wr_data_reg};
            op_valid_next = 1'b1;
            state_next = (state_reg == ST_FACT_SETUP) ? ST_FACT_BUSY : ST_BUSY;
          end else begin
            prog_err_next = 1'b1; // R11 R25
            erase_err_next = 1'b1; // R11 R25
            state_next = ST_IDLE; // R25
          end
        end
        ST_CFG_SETUP: begin
          state_next = ST_IDLE;
          if (code == CMD_LOCK) begin
            lock_next[blk] = 1'b1; // R17
          end else if (code == CMD_LOCK_DOWN) begin
            lock_next[blk] = 1'b1; // R17
            down_next[blk] = 1'b1; // R17
          end else if (code == CMD_CONFIRM) begin
            lock_next[blk] = down_reg[blk]; // R18
          end else if (code == CMD_SET_RCR) begin
            rcr_next = wr_addr_reg[RCR_W-1:0]; // R21
            mode_next = MODE_ARRAY; // R21
          end else begin
            prog_err_next = 1'b1; // R16 R20
            erase_err_next = 1'b1; // R16 R20
            mode_next = MODE_STATUS;
          end
        end
        ST_BUSY: begin
          if (code == CMD_READ_STATUS) begin
            mode_next = MODE_STATUS; // R4 R12
          end else if (code == CMD_SUSPEND && !algo_done) begin
            state_next = ST_SUSPENDED; // R13
            erase_susp_next = kind_reg == OP_ERASE; // R13
            prog_susp_next = kind_reg != OP_ERASE; // R13
          end
        end
        default: begin
          // Factory mode ignores every write until its algorithm ends
        end
      endcase
    end
    if (algo_done && (state_reg == ST_BUSY || state_reg == ST_FACT_BUSY)) begin
      state_next = ST_IDLE; // R6
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ST_IDLE; // R22
      mode_reg <= MODE_ARRAY; // R22
      kind_reg <= OP_NONE;
      op_reg <= '0;
      op_valid_reg <= 1'b0;
      prog_err_reg <= 1'b0;
      erase_err_reg <= 1'b0;
      prog_susp_reg <= 1'b0;
      erase_susp_reg <= 1'b0;
      left_reg <= '0;
      lock_reg <= '1;
      down_reg <= '0;
      rcr_reg <= '0;
    end else begin
      state_reg <= state_next;
      mode_reg <= mode_next;
      kind_reg <= kind_next;
      op_reg <= op_next;
      op_valid_reg <= op_valid_next;
      prog_err_reg <= prog_err_next;
      erase_err_reg <= erase_err_next;
      prog_susp_reg <= prog_susp_next;
      erase_susp_reg <= erase_susp_next;
      left_reg <= left_next;
      lock_reg <= lock_next;
      down_reg <= down_next;
      rcr_reg <= rcr_next;
    end
  end

  logic [7:0] status_now, shown_reg, shown_next;
  logic [DATA_W-1:0] dq_reg, dq_next;
  always_comb begin
    status_now = '0;
    status_now[READY_BIT] = ready; // R26
    status_now[ERASE_SUSP_BIT] = erase_susp_reg;
    status_now[ERASE_ERR_BIT] = erase_err_reg;
    status_now[PROG_ERR_BIT] = prog_err_reg;
    status_now[PROG_SUSP_BIT] = prog_susp_reg;
    // Latching stops the value changing under a read in progress
    shown_next = refresh ? status_now : shown_reg; // R5
    case (mode_reg)
      MODE_STATUS: dq_next = {8'h00, shown_reg}; // R23
      MODE_QUERY: dq_next = {8'h00, query_rdata}; // R1
      MODE_ID: dq_next = id_rdata;
      default: dq_next = array_rdata;
    endcase
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      shown_reg <= STATUS_RESET; // R22
      dq_reg <= '0;
    end else begin
      shown_reg <= shown_next;
      dq_reg <= dq_next;
    end
  end

  word_fifo #(.WIDTH($bits(buf_word_t)), .DEPTH(DEPTH)) load_fifo (
    .clk(clk),
    .arst_n(arst_n),
    .in_valid(fifo_push),
    .in_ready(fifo_in_ready),
    .in_data({wr_addr_reg, wr_data_reg}),
    .out_valid(buf_valid),
    .out_ready(buf_ready),
    .out_data(buf_word)
  );

  assign dq_out = dq_reg;
  assign dq_oe = ~filt_reg.ce_n & ~filt_reg.oe_n & filt_reg.we_n;
  assign op_valid = op_valid_reg;
  assign op = op_reg;
  assign algo_suspend = state_reg == ST_SUSPENDED;
  assign status = status_now;
  assign read_config = rcr_reg;
  assign block_locked = lock_reg;
  assign block_lockdown = down_reg;

  sequence s_cmd(logic [7:0] c);
    wr_evt_reg && code == c;
  endsequence
  sequence s_suspend_req;
    state_reg == ST_BUSY && !algo_done ##0 s_cmd(CMD_SUSPEND);
  endsequence
  a_query_mode: assert property (@(posedge clk) disable iff (!arst_n) // R1
    state_reg == ST_IDLE ##0 s_cmd(CMD_READ_QUERY) |=> mode_reg == MODE_QUERY ##1
    dq_out == {8'h00, $past(query_rdata)}) else $error("query mode not entered");
  a_clear_errs: assert property (@(posedge clk) disable iff (!arst_n) // R2
    state_reg == ST_IDLE ##0 s_cmd(CMD_CLEAR_STATUS) |=> !prog_err_reg && !erase_err_reg)
    else $error("errors not cleared");
  a_word_prog: assert property (@(posedge clk) disable iff (!arst_n) // R3
    state_reg == ST_PROG_SETUP && wr_evt_reg |=> op_valid && op.kind == OP_WORD
    && op.addr == $past(wr_addr_reg) && op.data == $past(wr_data_reg))
    else $error("word program not issued");
  a_busy_ignore: assert property (@(posedge clk) disable iff (!arst_n) // R4
    state_reg == ST_BUSY && wr_evt_reg && !algo_done && code != CMD_SUSPEND
    |=> state_reg == ST_BUSY && $stable(lock_reg) && !op_valid)
    else $error("busy took a command");
  a_erase_err: assert property (@(posedge clk) disable iff (!arst_n) // R11
    state_reg == ST_ERASE_SETUP && wr_evt_reg && code != CMD_CONFIRM
    |=> status[5:4] == 2'h3 && mode_reg == MODE_STATUS && state_reg == ST_IDLE)
    else $error("erase sequence error missed");
  a_suspend_flag: assert property (@(posedge clk) disable iff (!arst_n) // R13
    s_suspend_req |=> status[READY_BIT] && (status[PROG_SUSP_BIT] ^ status[ERASE_SUSP_BIT]))
    else $error("suspend not shown");
  a_stay_susp: assert property (@(posedge clk) disable iff (!arst_n) // R14
    state_reg == ST_SUSPENDED && !(wr_evt_reg && code == CMD_CONFIRM)
    |=> state_reg == ST_SUSPENDED) else $error("left suspension");
  a_resume_op: assert property (@(posedge clk) disable iff (!arst_n) // R15
    state_reg == ST_SUSPENDED ##0 s_cmd(CMD_CONFIRM) |=> !status[READY_BIT] && !algo_suspend)
    else $error("resume failed");
  a_lockdown_hold: assert property (@(posedge clk) disable iff (!arst_n) // R18
    state_reg == ST_CFG_SETUP && wr_evt_reg && code == CMD_CONFIRM && down_reg[blk]
    |=> block_locked[$past(blk)]) else $error("locked-down block unlocked");
  a_status_hold: assert property (@(posedge clk) disable iff (!arst_n) // R5
    mode_reg == MODE_STATUS && !refresh ##1 mode_reg == MODE_STATUS |=> $stable(dq_out))
    else $error("status changed without refresh");
endmodule
`default_nettype wire

// ==== tb/algo_engine_model.sv ====
// Behavioural algorithm engine and read data source behind the decoder
`timescale 1ns/1ns
`default_nettype none
module algo_engine_model
  import nor_flash_pkg::*;
#(
  parameter int DELAY = 20
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic hold,
  input wire logic stall,
  input wire logic op_valid,
  input wire op_t op,
  input wire logic algo_suspend,
  output logic algo_done,
  input wire logic buf_valid,
  input wire buf_word_t buf_word,
  output logic buf_ready,
  output logic [DATA_W-1:0] array_rdata,
  output logic [7:0] query_rdata,
  output logic [DATA_W-1:0] id_rdata
);
  logic running;
  int count;
  int ops;
  op_t last_op;
  buf_word_t got[$];
  assign array_rdata = 16'h5a3c;
  assign query_rdata = 8'h51;
  // Arbitrary value
  assign id_rdata = 16'h0c3a;
  // Stall lets the bench fill the load buffer until it refuses
  assign buf_ready = !stall;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      running <= 1'b0;
      count <= 0;
      ops <= 0;
      algo_done <= 1'b0;
    end else begin
      algo_done <= 1'b0;
      if (buf_valid && buf_ready) begin
        got.push_back(buf_word);
      end
      if (op_valid) begin
        running <= 1'b1;
        count <= 0;
        ops <= ops + 1;
        last_op <= op;
      end else if (running && !algo_suspend && !hold) begin
        // Work stops while suspended, but a suspend taken in the cycle the count ends still meets a done
        if (count == DELAY) begin
          algo_done <= 1'b1;
          running <= 1'b0;
        end else begin
          count <= count + 1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb/test_nor_flash_command_decoder.sv ====
// Self-checking bench of the NOR flash command decoder
`timescale 1ns/1ns
`default_nettype none
module test_nor_flash_command_decoder
  import nor_flash_pkg::*;
;
  localparam logic [23:0] BA = 24'h300000;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic ce_n = 1'b1;
  logic we_n = 1'b1;
  logic oe_n = 1'b1;
  logic address_valid_n = 1'b1;
  logic hold = 1'b1;
  logic stall = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] dq_in = '0;
  logic [DATA_W-1:0] dq_out, array_rdata, id_rdata, read_config, block_locked, block_lockdown;
  logic [7:0] query_rdata, status;
  logic dq_oe, op_valid, algo_suspend, algo_done, buf_valid, buf_ready;
  op_t op;
  buf_word_t buf_word;
  logic [15:0] r;
  int num_errors = 0;
  int checks_done = 0;
  logic [15:0] prot_code[4] = '{16'h00d0, 16'h0001, 16'h002f, 16'h00d0};
  logic [15:0] prot_lk[4] = '{16'hfff7, 16'hffff, 16'hffff, 16'hffff};
  logic [15:0] prot_ld[4] = '{16'h0000, 16'h0000, 16'h0008, 16'h0008};
  logic [15:0] seq[3] = '{16'h0020, 16'h0060, 16'h0080};
  always #20 clk = ~clk;
  nor_flash_command_decoder nor_flash_command_decoder_inst (.clk, .arst_n, .ce_n, .we_n,
    .oe_n, .address_valid_n, .addr, .dq_in, .dq_out, .dq_oe, .array_rdata, .query_rdata,
    .id_rdata, .op_valid, .op, .algo_suspend, .algo_done, .buf_valid, .buf_word,
    .buf_ready, .status, .read_config, .block_locked, .block_lockdown);
  algo_engine_model algo_engine_model_inst (.clk, .arst_n, .hold, .stall, .op_valid, .op,
    .algo_suspend, .algo_done, .buf_valid, .buf_word, .buf_ready, .array_rdata,
    .query_rdata, .id_rdata);
  task automatic summarize;
    if (num_errors == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_op(input logic [2:0] k, input int n);
    chk(16'(algo_engine_model_inst.last_op.kind), 16'(k), "op kind");
    chk(16'(algo_engine_model_inst.ops), 16'(n), "op count");
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Strobes are held low 4 cycles and high 10 cycles so the pin filter always sees them
  task automatic wr(input logic [23:0] a, input logic [15:0] d);
    @(posedge clk);
    ce_n <= 1'b0;
    we_n <= 1'b0;
    addr <= a;
    dq_in <= d;
    cyc(4);
    ce_n <= 1'b1;
    we_n <= 1'b1;
    cyc(10);
    chk(16'(dq_oe), 16'h0000, "dq released");
  endtask
  task automatic rd(output logic [15:0] d);
    @(posedge clk);
    ce_n <= 1'b0;
    oe_n <= 1'b0;
    cyc(8);
    d = dq_out;
    chk(16'(dq_oe), 16'h0001, "dq drive");
    ce_n <= 1'b1;
    oe_n <= 1'b1;
    cyc(4);
  endtask
  task automatic wait_ready;
    int i;
    hold <= 1'b0;
    for (i = 0; i < 500 && status[READY_BIT] !== 1'b1; i++) @(posedge clk);
    hold <= 1'b1;
    if (i == 500) begin
      num_errors++;
      $display("unexpected at %0t: ready timeout", $time);
      summarize();
    end
  endtask
  initial begin
    cyc(16);
    arst_n <= 1'b1;
    cyc(2);
    chk(status, 16'h0080, "reset status");
    rd(r); chk(r, 16'h5a3c, "array");
    wr(0, 16'h0098); rd(r); chk(r[7:0], 8'h51, "query");
    wr(24'h000100, 16'h0040); wr(24'h000100, 16'h1234);
    chk_op(OP_WORD, 1); chk({op.addr[15:0]}, 16'h0100, "op addr");
    chk(op.data, 16'h1234, "op data"); chk(status, 16'h0000, "busy");
    wr(0, 16'h0020); wr(0, 16'h00d0); chk_op(OP_WORD, 1);
    wr(0, 16'h00b0); chk(status, 16'h0084, "prog susp");
    wr(0, 16'h00d0); chk(status, 16'h0000, "resumed");
    // Select held low across completion: shown status must not refresh
    @(posedge clk); ce_n <= 1'b0; oe_n <= 1'b0; cyc(8);
    wait_ready(); cyc(4); chk(dq_out[7:0], 8'h00, "stale status");
    ce_n <= 1'b1; oe_n <= 1'b1; cyc(4);
    rd(r); chk(r[7:0], 8'h80, "status mode");
    wr(0, 16'h00ff); rd(r); chk(r, 16'h5a3c, "array again");
    wr(0, 16'h0090);
    rd(r);
    chk(r, 16'h0c3a, "id");
    wr(0, 16'h0070);
    rd(r);
    chk(r[7:0], 8'h80, "status cmd");
    wr(BA, 16'h0020); wr(BA, 16'h00d0); chk_op(OP_ERASE, 2);
    chk(op.addr[23:8], BA[23:8], "erase addr");
    wr(0, 16'h0040); chk_op(OP_ERASE, 2);
    wr(0, 16'h00b0); chk(algo_suspend, 1'b1, "susp"); chk(status, 16'h00c0, "er susp");
    // Last select fall latched busy status; here the address-valid fall alone refreshes it to show suspend
    address_valid_n <= 1'b0;
    cyc(8);
    chk(dq_out[7:0], 8'hc0, "adv refresh");
    address_valid_n <= 1'b1;
    wr(0, 16'h0020); chk(status, 16'h00c0, "still susp");
    wr(0, 16'h00d0); chk(algo_suspend, 1'b0, "resume");
    wait_ready();
    foreach (seq[i]) begin
      wr(0, seq[i]); wr(0, 16'h0077); chk(status, 16'h00b0, "seq err");
      rd(r); chk(r[7:0], 8'hb0, "err shown");
      wr(0, 16'h0050); chk(status, 16'h0080, "cleared");
    end
    foreach (prot_code[i]) begin
      wr(BA, 16'h0060); wr(BA, prot_code[i]);
      chk(block_locked, prot_lk[i], "locked"); chk(block_lockdown, prot_ld[i], "down");
    end
    wr(24'h00abcd, 16'h0060); wr(24'h01beef, 16'h0003);
    chk(read_config, 16'hbeef, "config"); rd(r); chk(r, 16'h5a3c, "array");
    // Strobe rises first, data changes before select rises: the early code must win
    @(posedge clk);
    ce_n <= 1'b0;
    we_n <= 1'b0;
    dq_in <= 16'h0098;
    cyc(4);
    we_n <= 1'b1;
    cyc(6);
    dq_in <= 16'h00ff;
    cyc(6);
    ce_n <= 1'b1;
    cyc(6);
    rd(r);
    chk(r[7:0], 8'h51, "early strobe");
    wr(24'h000080, 16'h00c0); wr(24'h000081, 16'hcafe); chk_op(OP_OTP, 3);
    chk(op.data, 16'hcafe, "otp data"); wait_ready();
    stall <= 1'b1;
    wr(24'h000400, 16'h00e8); wr(24'h000400, 16'h0008);
    for (int k = 0; k < 9; k++) wr(24'h000400 + 24'(k), 16'h1000 + 16'(k));
    chk(status, 16'h0090, "buffer full"); chk(buf_valid, 1'b1, "buf held");
    stall <= 1'b0;
    cyc(40);
    for (int k = 0; k < 8; k++) chk(algo_engine_model_inst.got[k].data, 16'h1000 + 16'(k), "buf");
    chk(buf_valid, 1'b0, "drained");
    wr(24'h000400, 16'h00d0); chk_op(OP_BUFFER, 4); wait_ready();
    wr(0, 16'h0050);
    wr(24'h000500, 16'h0080); wr(24'h000500, 16'h00d0); chk_op(OP_FACTORY, 5);
    wr(0, 16'h00b0); chk(algo_suspend, 1'b0, "factory"); wait_ready();
    wr(BA, 16'h0020); wr(BA, 16'h00d0); wr(0, 16'h00b0);
    arst_n <= 1'b0;
    cyc(2);
    arst_n <= 1'b1;
    cyc(2);
    chk(algo_suspend, 1'b0, "reset susp"); chk(status, 16'h0080, "reset");
    summarize();
  end
endmodule
`default_nettype wire
